// *** hdl/meter_status_lock_pulse_regs.v ***
// Pulse, lock, phase sequence, checksum and status registers of the meter.
// Assumes decoded host and engine accesses and one-cycle events on clk_i.
`timescale 1ns/1ns
`include "meter_regs_consts.vh"

module meter_status_lock_pulse_regs #(
   parameter DATA_W = 24
) (
   input  wire              clk_i,
   input  wire              rst_b_i,
   // Host register access from the serial port.
   input  wire              host_wr_i,
   input  wire              host_rd_i,
   input  wire [5:0]        host_page_i,
   input  wire [5:0]        host_addr_i,
   input  wire [DATA_W-1:0] host_wdata_i,
   output reg  [DATA_W-1:0] host_rdata_o,
   output reg               host_rvalid_o,
   output reg               host_wr_refused_o,
   // Internal calculation engine write access.
   input  wire              eng_wr_i,
   input  wire [5:0]        eng_page_i,
   input  wire [5:0]        eng_addr_i,
   input  wire [DATA_W-1:0] eng_wdata_i,
   output reg               eng_wr_refused_o,
   // Timing and phase inputs.
   input  wire              owr_strobe_i,
   input  wire              volt_negative_i,
   input  wire              csum_update_i,
   // Event pulses from the engine and serial port.
   input  wire              low_rate_update_i,
   input  wire              host_instr_done_i,
   input  wire              reset_seq_done_i,
   input  wire              sample_update_i,
   input  wire              watchdog_overflow_i,
   input  wire              engine_overrun_i,
   input  wire [1:0]        swell_i,
   input  wire [5:0]        range_i,
   input  wire [1:0]        overcurrent_i,
   input  wire [1:0]        sag_i,
   input  wire              temperature_updated_i,
   input  wire              line_ratio_updated_i,
   input  wire              invalid_command_i,
   input  wire              receive_checksum_error_i,
   input  wire              receive_timeout_i,
   input  wire              cmd_exec_i,
   input  wire [7:0]        cmd_code_i,
   input  wire [3:0]        oscillation_i,
   // Settings towards the pulse generators, lock states and interrupt request.
   output wire [3:0]        pulse_freq_range_o,
   output wire [15:0]       pulse_duration_field_o,
   output wire [DATA_W-1:0] pulse_rate_o,
   output wire [15:0]       pulse_gen_source_o,
   output wire [3:0]        pulse_gen_valid_o,
   output wire              engine_locked_o,
   output wire              host_locked_o,
   output wire              irq_o
);

   // ------------------------------------------------------------------
   // Register index decode
   // ------------------------------------------------------------------
   localparam IX_NONE = 4'h0;
   localparam IX_IEN  = 4'h1;
   localparam IX_PWID = 4'h2;
   localparam IX_PSRC = 4'h3;
   localparam IX_IST  = 4'h4;
   localparam IX_CST  = 4'h5;
   localparam IX_LOCK = 4'h6;
   localparam IX_PSD  = 4'h7;
   localparam IX_CSUM = 4'h8;
   localparam IX_RATE = 4'h9;

   // Maps a page and word address onto a register index.
   function [3:0] reg_index;
      input [5:0] page;
      input [5:0] addr;
      begin
         reg_index = IX_NONE;
         if (page == `PG_CTRL) begin
            case (addr)
               `AD_INT_ENABLE:  reg_index = IX_IEN;
               `AD_PULSE_WIDTH: reg_index = IX_PWID;
               `AD_PULSE_SRC:   reg_index = IX_PSRC;
               `AD_INT_STATUS:  reg_index = IX_IST;
               `AD_CHIP_STATUS: reg_index = IX_CST;
               `AD_LOCK_KEYS:   reg_index = IX_LOCK;
               `AD_PHASE_SEQ:   reg_index = IX_PSD;
               default:         reg_index = IX_NONE;
            endcase
         end else if (page == `PG_CALC && addr == `AD_CFG_CHECKSUM) begin
            reg_index = IX_CSUM;
         end else if (page == `PG_RATE && addr == `AD_PULSE_RATE) begin
            reg_index = IX_RATE;
         end
      end
   endfunction

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   reg  [DATA_W-1:0] int_enable;
   reg  [DATA_W-1:0] pulse_width;
   reg  [DATA_W-1:0] pulse_source_select;
   reg  [DATA_W-1:0] interrupt_status;
   reg  [DATA_W-1:0] chip_status_word;
   reg  [DATA_W-1:0] write_lock_keys;
   reg  [DATA_W-1:0] pulse_full_scale_rate;
   reg  [DATA_W-1:0] critical_config_checksum;
   reg               engine_locked;
   reg               host_locked;
   reg  [6:0]        sequence_count;
   reg               sequence_done;
   reg               sequence_active;
   reg               edge_dir;
   reg               prev_negative;

   wire [3:0]        host_ix;
   wire [3:0]        eng_ix;
   wire              host_exempt;
   wire              host_we;
   wire              host_we_rate;
   wire              eng_we;
   reg  [DATA_W-1:0] next_rdata;
   reg  [DATA_W-1:0] status_set;
   reg  [DATA_W-1:0] status_clr;
   wire              crossing_hit;

   assign host_ix = reg_index(host_page_i, host_addr_i);
   assign eng_ix  = reg_index(eng_page_i, eng_addr_i);

   // ------------------------------------------------------------------
   // Write qualification
   // ------------------------------------------------------------------
   // Lock and status words stay writable so a locked host can recover.
   // host write block
   assign host_exempt = (host_ix == IX_LOCK) || (host_ix == IX_IST) || (host_ix == IX_CST);
   assign host_we     = host_wr_i && (!host_locked || host_exempt);
   // Host wins when both write the rate.
   assign host_we_rate = host_we && (host_ix == IX_RATE);
   assign eng_we      = eng_wr_i && !engine_locked && (eng_ix == IX_RATE) && !host_we_rate;

   // Refusal indications, one cycle after the attempt.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         host_wr_refused_o <= 1'b0;
         eng_wr_refused_o  <= 1'b0;
      end else begin
         host_wr_refused_o <= host_wr_i && !host_we;
         eng_wr_refused_o  <= eng_wr_i && !eng_we;
      end
   end

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   // Enable mask, pulse width, sources, rate and lock keys.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         int_enable            <= `RST_INT_ENABLE;
         pulse_width           <= `RST_PULSE_WIDTH;
         pulse_source_select   <= `RST_PULSE_SRC;
         pulse_full_scale_rate <= `RST_PULSE_RATE;
         write_lock_keys       <= `RST_LOCK_KEYS;
         engine_locked         <= 1'b0;
         host_locked           <= 1'b0;
      end else begin
         if (host_we && host_ix == IX_IEN)
            int_enable <= host_wdata_i & `ST_IMPL_MASK;
         if (host_we && host_ix == IX_PWID) begin
            pulse_width[15:0] <= host_wdata_i[15:0];
            if (host_wdata_i[`PULSE_FREQ_RANGE_LSB+3:`PULSE_FREQ_RANGE_LSB] <= `PULSE_FREQ_RANGE_MAX)
               pulse_width[`PULSE_FREQ_RANGE_LSB+3:`PULSE_FREQ_RANGE_LSB] <=
                  host_wdata_i[`PULSE_FREQ_RANGE_LSB+3:`PULSE_FREQ_RANGE_LSB];
         end
         if (host_we && host_ix == IX_PSRC)
            pulse_source_select <= host_wdata_i & `SRC_FIELD_MASK;
         if (host_we_rate)
            pulse_full_scale_rate <= host_wdata_i;
         else if (eng_we)
            pulse_full_scale_rate <= eng_wdata_i;
         if (host_we && host_ix == IX_LOCK) begin
            write_lock_keys <= host_wdata_i & `LOCK_FIELD_MASK;
            if (host_wdata_i[`ENG_KEY_LSB+4:`ENG_KEY_LSB] == `KEY_LOCK)
               engine_locked <= 1'b1;
            else if (host_wdata_i[`ENG_KEY_LSB+4:`ENG_KEY_LSB] == `KEY_UNLOCK)
               engine_locked <= 1'b0;
            if (host_wdata_i[`HOST_KEY_LSB+4:`HOST_KEY_LSB] == `KEY_LOCK)
               host_locked <= 1'b1;
            else if (host_wdata_i[`HOST_KEY_LSB+4:`HOST_KEY_LSB] == `KEY_UNLOCK)
               host_locked <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Pulse generator settings
   // ------------------------------------------------------------------
   // rate passed to generators
   assign pulse_rate_o           = pulse_full_scale_rate;
   assign pulse_freq_range_o     = pulse_width[`PULSE_FREQ_RANGE_LSB+3:`PULSE_FREQ_RANGE_LSB];
   assign pulse_duration_field_o = pulse_width[15:0];
   assign pulse_gen_source_o     = pulse_source_select[15:0];
   assign engine_locked_o        = engine_locked;
   assign host_locked_o          = host_locked;

   // Flags each generator whose source code is defined.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_src
         assign pulse_gen_valid_o[g] = (pulse_source_select[4*g+3:4*g] <= `SRC_CODE_MAX);
      end
   endgenerate

   // ------------------------------------------------------------------
   // Phase sequence detection
   // ------------------------------------------------------------------
   // A sign change between successive samples; the direction bit picks one.
   // direction selects edge
   assign crossing_hit = owr_strobe_i &&
                         (edge_dir ? (!prev_negative && volt_negative_i)
                                   : (prev_negative && !volt_negative_i));

   // Counter, done flag and direction.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         sequence_count  <= 7'h00;
         sequence_done   <= 1'b0;
         sequence_active <= 1'b0;
         edge_dir        <= 1'b0;
         prev_negative   <= 1'b0;
      end else begin
         if (owr_strobe_i)
            prev_negative <= volt_negative_i;
         if (host_we && host_ix == IX_PSD) begin
            edge_dir <= host_wdata_i[`PSD_DIR_BIT];
            if (host_wdata_i[4:0] == `PSD_START_KEY) begin
               sequence_active <= 1'b1;
               sequence_done   <= 1'b0;
               sequence_count  <= 7'h00;
            end
         end else if (sequence_active) begin
            if (crossing_hit) begin
               sequence_active <= 1'b0;
               sequence_done   <= 1'b1;
            end else if (owr_strobe_i && sequence_count != `PSD_CNT_MAX) begin
               sequence_count <= sequence_count + 7'h01;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Checksum of critical registers
   // ------------------------------------------------------------------
   // checksum loaded on request
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         critical_config_checksum <= `RST_CFG_CHECKSUM;
      end else if (csum_update_i) begin
         critical_config_checksum <= pulse_width + pulse_source_select + pulse_full_scale_rate
                                     + int_enable;
      end
   end

   // ------------------------------------------------------------------
   // Interrupt status
   // ------------------------------------------------------------------
   // Places each event pulse on its flag.
   always @* begin
      status_set = {DATA_W{1'b0}};
      status_set[`ST_LOW_RATE_DONE] = low_rate_update_i | host_instr_done_i | reset_seq_done_i;
      status_set[`ST_SAMPLE_DONE] = sample_update_i;
      status_set[`ST_WATCHDOG] = watchdog_overflow_i;
      status_set[`ST_ENGINE_OVERRUN] = engine_overrun_i;
      status_set[`ST_SWELL_LSB+1:`ST_SWELL_LSB] = swell_i;
      status_set[`ST_SAG_LSB+1:`ST_SAG_LSB] = sag_i;
      status_set[`ST_TEMP_UPD] = temperature_updated_i;
      status_set[`ST_LINE_RATIO_UPD] = line_ratio_updated_i;
      status_set[`ST_RANGE_LSB+5:`ST_RANGE_LSB] = range_i;
      status_set[`ST_OVERCURRENT_LSB+1:`ST_OVERCURRENT_LSB] = overcurrent_i;
      status_set[`ST_INVALID_CMD] = invalid_command_i;
      status_set[`ST_RECEIVE_CHECKSUM_ERROR] = receive_checksum_error_i;
      status_set[`ST_RX_TIMEOUT] = receive_timeout_i;
      status_clr = (host_we && host_ix == IX_IST) ? host_wdata_i : {DATA_W{1'b0}};
   end

   // A flag raised in the cycle it is cleared stays set.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         interrupt_status <= `RST_INT_STATUS;
      end else begin
         interrupt_status <= ((interrupt_status & ~status_clr) | status_set) & `ST_IMPL_MASK;
      end
   end

   assign irq_o = |(interrupt_status & int_enable);

   // ------------------------------------------------------------------
   // Chip status word
   // ------------------------------------------------------------------
   // Last command and sticky oscillation flags.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         chip_status_word <= `RST_CHIP_STATUS;
      end else begin
         if (cmd_exec_i)
            chip_status_word[`CS_CMD_LSB+7:`CS_CMD_LSB] <= cmd_code_i;
         chip_status_word[3:0] <= chip_status_word[3:0] | oscillation_i;
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   // Selects the addressed word; unmapped addresses read zero.
   always @* begin
      case (host_ix)
         IX_IEN:  next_rdata = int_enable;
         IX_PWID: next_rdata = pulse_width;
         IX_PSRC: next_rdata = pulse_source_select;
         IX_IST:  next_rdata = interrupt_status;
         IX_CST:  next_rdata = chip_status_word;
         IX_LOCK: next_rdata = write_lock_keys;
         IX_PSD:  next_rdata = {sequence_done, sequence_count, 10'h000, edge_dir, 5'h00};
         IX_CSUM: next_rdata = critical_config_checksum;
         IX_RATE: next_rdata = pulse_full_scale_rate;
         default: next_rdata = {DATA_W{1'b0}};
      endcase
   end

   // Read data registered one cycle after the request.
   always @(posedge clk_i) begin
      if (!rst_b_i) begin
         host_rdata_o  <= {DATA_W{1'b0}};
         host_rvalid_o <= 1'b0;
      end else begin
         host_rvalid_o <= host_rd_i;
         if (host_rd_i)
            host_rdata_o <= next_rdata;
      end
   end

endmodule // meter_status_lock_pulse_regs

// *** hdl/meter_regs_consts.vh ***
// Constants for the meter status, lock and pulse register group.
// Assumes it is included by bare name from the register bank module.
`ifndef METER_REGS_CONSTS_VH
`define METER_REGS_CONSTS_VH

// ----------------------------------------------------------------------
// Register locations (page, word address)
// ----------------------------------------------------------------------
`define PG_CTRL              6'h00
`define PG_CALC              6'h10
`define PG_RATE              6'h12
`define AD_INT_ENABLE        6'h03
`define AD_PULSE_WIDTH       6'h08
`define AD_PULSE_SRC         6'h09
`define AD_INT_STATUS        6'h17
`define AD_CHIP_STATUS       6'h18
`define AD_LOCK_KEYS         6'h22
`define AD_PHASE_SEQ         6'h30
`define AD_CFG_CHECKSUM      6'h01
`define AD_PULSE_RATE        6'h1C

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_INT_ENABLE       24'h000000
`define RST_PULSE_WIDTH      24'h000001
`define RST_PULSE_SRC        24'h000000
`define RST_INT_STATUS       24'h800000
`define RST_CHIP_STATUS      24'h801800
`define RST_LOCK_KEYS        24'h000000
`define RST_CFG_CHECKSUM     24'h000000
`define RST_PULSE_RATE       24'h800000

// ----------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------
`define PULSE_FREQ_RANGE_LSB         16
`define PULSE_FREQ_RANGE_MAX         4'h9
`define SRC_CODE_MAX         4'h8
`define SRC_FIELD_MASK       24'h00FFFF
`define ENG_KEY_LSB          8
`define HOST_KEY_LSB         0
`define KEY_LOCK             5'h16
`define KEY_UNLOCK           5'h09
`define LOCK_FIELD_MASK      24'h001F1F
`define PSD_DIR_BIT          5
`define PSD_START_KEY        5'h16
`define PSD_CNT_MAX          7'h7F
`define ST_LOW_RATE_DONE     23
`define ST_SAMPLE_DONE       22
`define ST_WATCHDOG          21
`define ST_ENGINE_OVERRUN    18
`define ST_SWELL_LSB         16
`define ST_RANGE_LSB         10
`define ST_OVERCURRENT_LSB   8
`define ST_SAG_LSB           6
`define ST_TEMP_UPD          5
`define ST_LINE_RATIO_UPD    4
`define ST_INVALID_CMD       3
`define ST_RECEIVE_CHECKSUM_ERROR       2
`define ST_RX_TIMEOUT        0
`define ST_IMPL_MASK         24'hE7FFFD
`define CS_CMD_LSB           8

`endif

// *** tb/meter_regs_monitor.sv ***
// Assertion checker for the meter register bank, on its top-level ports.
// Assumes it is bound into the bank, one host access per cycle.
`timescale 1ns/1ns
`include "meter_regs_consts.vh"

module meter_regs_monitor #(
   parameter DATA_W = 24
) (
   input wire logic              clk_i,
   input wire logic              rst_b_i,
   input wire logic              host_wr_i,
   input wire logic              host_rd_i,
   input wire logic [5:0]        host_page_i,
   input wire logic [5:0]        host_addr_i,
   input wire logic [DATA_W-1:0] host_wdata_i,
   input wire logic              host_rvalid_o,
   input wire logic              host_wr_refused_o,
   input wire logic              eng_wr_i,
   input wire logic              eng_wr_refused_o,
   input wire logic              sample_update_i,
   input wire logic [3:0]        pulse_freq_range_o,
   input wire logic [DATA_W-1:0] pulse_rate_o,
   input wire logic [15:0]       pulse_gen_source_o,
   input wire logic [3:0]        pulse_gen_valid_o,
   input wire logic              engine_locked_o,
   input wire logic              host_locked_o,
   input wire logic              irq_o
);
   // ------------------------------------------------------------------
   // Port relations
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // Decode of an unlocked host write and its page and word address.
   wire        free_wr = host_wr_i && !host_locked_o;
   wire [11:0] wloc    = {host_page_i, host_addr_i};

   property p_rd_answer;
      host_rd_i |=> host_rvalid_o;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("Read unanswered.");

   property p_lock_refuse;
      host_wr_i && host_locked_o && wloc == {`PG_CTRL, `AD_PULSE_SRC}
         |=> host_wr_refused_o && $stable(pulse_gen_source_o);
   endproperty
   a_lock_refuse: assert property (p_lock_refuse) else $error("Locked host write taken.");

   property p_eng_refuse;
      eng_wr_i && engine_locked_o |=> eng_wr_refused_o;
   endproperty
   a_eng_refuse: assert property (p_eng_refuse) else $error("Locked engine write taken.");

   property p_src_valid;
      pulse_gen_valid_o == {pulse_gen_source_o[15:12] <= `SRC_CODE_MAX,
         pulse_gen_source_o[11:8] <= `SRC_CODE_MAX, pulse_gen_source_o[7:4] <= `SRC_CODE_MAX,
         pulse_gen_source_o[3:0] <= `SRC_CODE_MAX};
   endproperty
   a_src_valid: assert property (p_src_valid) else $error("Source valid flags wrong.");

   property p_irq_off;
      free_wr && wloc == {`PG_CTRL, `AD_INT_ENABLE} && host_wdata_i == 24'h000000 |=> !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("Masked request.");

   // enabled sample flag raises the request
   sequence s_arm_sample;
      free_wr && wloc == {`PG_CTRL, `AD_INT_ENABLE} && host_wdata_i[`ST_SAMPLE_DONE]
         ##1 !host_wr_i ##1 sample_update_i && !host_wr_i;
   endsequence
   property p_irq_on;
      s_arm_sample |=> irq_o;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("Flag gave no request.");

   property p_rate_write;
      free_wr && wloc == {`PG_RATE, `AD_PULSE_RATE} |=> pulse_rate_o == $past(host_wdata_i);
   endproperty
   a_rate_write: assert property (p_rate_write) else $error("Rate word not stored.");

   property p_range_keep;
      free_wr && wloc == {`PG_CTRL, `AD_PULSE_WIDTH} && host_wdata_i[19:16] > `PULSE_FREQ_RANGE_MAX
         |=> $stable(pulse_freq_range_o);
   endproperty
   a_range_keep: assert property (p_range_keep) else $error("Reserved range accepted.");
endmodule // meter_regs_monitor

// *** tb/host_port_model.sv ***
// Host controller model for the serial register port of the bank.
// Assumes decoded accesses, requests changed only at the falling clock edge.
`timescale 1ns/1ns

module host_port_model (
   input  wire logic        clk_i,
   input  wire logic [23:0] host_rdata_o,
   input  wire logic        host_rvalid_o,
   input  wire logic        host_wr_refused_o,
   output logic             host_wr_i,
   output logic             host_rd_i,
   output logic [5:0]       host_page_i,
   output logic [5:0]       host_addr_i,
   output logic [23:0]      host_wdata_i
);
   // Idle port: strobes low, address parked off the map.
   initial begin
      host_wr_i = 1'b0;
      host_rd_i = 1'b0;
      {host_page_i, host_addr_i} = 12'hFFF;
      host_wdata_i = 24'h000000;
   end

   // One write strobe; released lines then show the inverse.
   task automatic wr(input logic [11:0] loc, input logic [23:0] d, output logic refused);
      @(negedge clk_i);
      {host_page_i, host_addr_i} = loc;
      host_wdata_i = d;
      host_wr_i = 1'b1;
      @(negedge clk_i);
      host_wr_i = 1'b0;
      refused = host_wr_refused_o;
      {host_page_i, host_addr_i} = ~loc;
      host_wdata_i = ~d;
   endtask

   // One read strobe, then a bounded wait for valid.
   task automatic rd(input logic [11:0] loc, output logic [23:0] d);
      int n;
      @(negedge clk_i);
      {host_page_i, host_addr_i} = loc;
      host_rd_i = 1'b1;
      @(negedge clk_i);
      host_rd_i = 1'b0;
      {host_page_i, host_addr_i} = ~loc;
      n = 0;
      while (host_rvalid_o !== 1'b1 && n < 4) begin
         @(negedge clk_i);
         n++;
      end
      d = (host_rvalid_o === 1'b1) ? host_rdata_o : 24'hXXXXXX;
   endtask
endmodule // host_port_model

// *** tb/meter_status_lock_pulse_regs_tb.sv ***
// Self-checking bench for the meter status, lock and pulse register bank.
// Assumes the constants header on the include path and the host model.
`timescale 1ns/1ns
`include "meter_regs_consts.vh"

module meter_status_lock_pulse_regs_tb;
   localparam logic [11:0] EN = {`PG_CTRL, `AD_INT_ENABLE}, SRC = {`PG_CTRL, `AD_PULSE_SRC};
   localparam logic [11:0] ST = {`PG_CTRL, `AD_INT_STATUS}, CS = {`PG_CTRL, `AD_CHIP_STATUS};
   localparam logic [11:0] LK = {`PG_CTRL, `AD_LOCK_KEYS}, PS = {`PG_CTRL, `AD_PHASE_SEQ};
   localparam logic [11:0] CK = {`PG_CALC, `AD_CFG_CHECKSUM}, RATE = {`PG_RATE, `AD_PULSE_RATE};
   localparam logic [11:0] PW = {`PG_CTRL, `AD_PULSE_WIDTH};
   localparam logic [11:0] LOCS [8] = '{EN, SRC, ST, CS, LK, PS, CK, RATE};
   localparam logic [23:0] RSTS [8] = '{24'h000000, 24'h000000, 24'h800000, 24'h801800,
                                        24'h000000, 24'h000000, 24'h000000, 24'h800000};
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        eng_wr_i = 1'b0, owr_strobe_i = 1'b0, volt_negative_i = 1'b0;
   logic        cmd_exec_i = 1'b0;
   logic [7:0]  cmd_code_i = 8'h00;
   logic [3:0]  oscillation_i = 4'h0;
   logic [11:0] eng_loc = 12'h000;
   logic [23:0] eng_wdata_i = 24'h000000, ev = 24'h000000, rdv;
   logic        refd;
   int          fails = 0, tests_run = 0, cycles = 0, e;
   wire         host_wr_i, host_rd_i, host_rvalid_o, host_wr_refused_o, eng_wr_refused_o;
   wire  [5:0]  host_page_i, host_addr_i;
   wire  [23:0] host_wdata_i, host_rdata_o, pulse_rate_o;
   wire  [3:0]  pulse_freq_range_o, pulse_gen_valid_o;
   wire  [15:0] pulse_duration_field_o, pulse_gen_source_o;
   wire         engine_locked_o, host_locked_o, irq_o;
   wire  [5:0]  eng_page_i = eng_loc[11:6], eng_addr_i = eng_loc[5:0];
   // Event lines come from one vector, placed on the flag they set, except bits 20 and 19 (flag 23) and bit 1 (checksum load).
   wire low_rate_update_i = ev[23], sample_update_i = ev[22], watchdog_overflow_i = ev[21];
   wire host_instr_done_i = ev[20], reset_seq_done_i = ev[19], engine_overrun_i = ev[18];
   wire [1:0] swell_i = ev[17:16], overcurrent_i = ev[9:8], sag_i = ev[7:6];
   wire [5:0] range_i = ev[15:10];
   wire temperature_updated_i = ev[5], line_ratio_updated_i = ev[4], invalid_command_i = ev[3];
   wire receive_checksum_error_i = ev[2], csum_update_i = ev[1], receive_timeout_i = ev[0];

   meter_status_lock_pulse_regs #(.DATA_W(24)) DUT (.*);
   host_port_model hm (.*);

   // Clock, and a cycle ceiling that cuts a hang short.
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         stop_test();
      end
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [23:0] got, input logic [23:0] want);
      tests_run++;
      if (got !== want) begin
         fails++;
         $display("ERROR t=%0t got=%h want=%h", $time, got, want);
      end
   endtask
   task automatic rcheck(input logic [11:0] loc, input logic [23:0] want);
      hm.rd(loc, rdv);
      chk(rdv, want);
   endtask
   task automatic pulse(input logic [23:0] v);
      @(negedge clk_i);
      ev = v;
      @(negedge clk_i);
      ev = 24'h000000;
   endtask
   task automatic output_word_rate(input logic neg);
      @(negedge clk_i);
      volt_negative_i = neg;
      owr_strobe_i = 1'b1;
      @(negedge clk_i);
      owr_strobe_i = 1'b0;
   endtask
   task automatic ewr(input logic [11:0] loc, input logic [23:0] d, input logic want);
      @(negedge clk_i);
      eng_loc = loc;
      eng_wdata_i = d;
      eng_wr_i = 1'b1;
      @(negedge clk_i);
      eng_wr_i = 1'b0;
      chk(eng_wr_refused_o, want);
      eng_loc = ~loc;
      eng_wdata_i = ~d;
   endtask
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      rst_b_i = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rcheck(LOCS[i], RSTS[i]);
      end
      rcheck({`PG_CTRL, 6'h3F}, 24'h000000);
      hm.wr(ST, 24'hFFFFFF, refd);
      rcheck(ST, 24'h000000);
      // Every flag: set it, keep it under zeros, clear it, watch the request.
      for (int b = 0; b < 24; b++) begin
         if (b != 1) begin
            e = (b == 19 || b == 20) ? 23 : b;
            hm.wr(EN, 24'h1 << e, refd);
            pulse(24'h1 << b);
            chk(irq_o, 1'b1);
            hm.wr(ST, ~(24'h1 << e), refd);
            rcheck(ST, 24'h1 << e);
            hm.wr(ST, 24'h1 << e, refd);
            chk(irq_o, 1'b0);
         end
      end
      hm.wr(EN, 24'h000000, refd);
      // Command code and oscillation flags; host writes are ignored.
      @(negedge clk_i);
      cmd_code_i = 8'hA5;
      cmd_exec_i = 1'b1;
      oscillation_i = 4'h9;
      @(negedge clk_i);
      cmd_exec_i = 1'b0;
      oscillation_i = 4'h0;
      hm.wr(CS, 24'h000000, refd);
      rcheck(CS, 24'h80A509);
      // Sources, range codes and full-scale rate.
      hm.wr(SRC, 24'hABC876, refd);
      rcheck(SRC, 24'h00C876);
      chk(pulse_gen_valid_o, 4'h7);
      hm.wr(PW, 24'h090007, refd);
      chk(pulse_freq_range_o, 4'h9);
      hm.wr(PW, 24'h0A0005, refd);
      rcheck(PW, 24'h090005);
      chk(pulse_duration_field_o, 24'h000005);
      hm.wr(RATE, 24'h7FFFFF, refd);
      chk(pulse_rate_o, 24'h7FFFFF);
      // Host lock, then engine lock on the rate word.
      hm.wr(LK, 24'h000016, refd);
      hm.wr(SRC, 24'h000000, refd);
      chk(refd, 1'b1);
      hm.wr(ST, 24'hFFFFFF, refd);
      chk(refd, 1'b0);
      rcheck(SRC, 24'h00C876);
      hm.wr(LK, 24'h000009, refd);
      chk(host_locked_o, 1'b0);
      hm.wr(LK, 24'h001600, refd);
      chk(engine_locked_o, 1'b1);
      ewr(RATE, 24'h123456, 1'b1);
      hm.wr(LK, 24'h000900, refd);
      ewr(RATE, 24'h123456, 1'b0);
      rcheck(RATE, 24'h123456);
      pulse(24'h000002);
      rcheck(CK, 24'h1BFCD1);
      // Phase sequence: falling stop, then rising stop.
      hm.wr(PS, 24'h000036, refd);
      output_word_rate(1'b0);
      output_word_rate(1'b0);
      rcheck(PS, 24'h020020);
      output_word_rate(1'b0);
      output_word_rate(1'b1);
      rcheck(PS, 24'h830020);
      hm.wr(PS, 24'h000016, refd);
      output_word_rate(1'b1);
      output_word_rate(1'b0);
      rcheck(PS, 24'h810000);
      stop_test();
   end
endmodule // meter_status_lock_pulse_regs_tb

bind meter_status_lock_pulse_regs meter_regs_monitor #(.DATA_W(DATA_W)) u_mon (.*);
